//--- pds_host_model.sv
/*
  Host and supply model: supply trip, system-on request and oscillator.
  Assumes the bench sets its commands just after a clock edge.
*/
`timescale 1ns/1ps
module pds_host_model (
  // Commands from the bench
  input  wire logic       trip_in,
  input  wire logic       off_in,
  input  wire logic [9:0] osc_half_in,
  // Pins towards the sequencer
  output logic            supply_low_out,
  output logic            request_out,
  output logic            osc_out
);
  // ************************************************************
  // Pins
  // ************************************************************
  assign supply_low_out = trip_in;
  assign request_out    = ~off_in;
  // Offset keeps oscillator edges off the block clock edges; zero stops it
  initial begin
    osc_out = 1'b0;
    #7;
    forever begin
      if (osc_half_in == 10'h000) begin
        #50;
      end else begin
        #(osc_half_in) osc_out = ~osc_out;
      end
    end
  end
endmodule // pds_host_model

//--- pds_pkg.sv
/*
  Constants, states and carrier type of the power-down sequencer.
  Assumes a 40 MHz block clock; times are converted to cycles here.
*/
package pds_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_MHZ          = 40;
  localparam int unsigned T_MON4_MIN_US    = 52;
  localparam int unsigned T_MON4_MAX_US    = 120;
  localparam int unsigned T_MON5_MAX_US    = 1000;
  localparam int unsigned T_PARK_MAX_US    = 280;
  localparam int unsigned T_W2_MAX_US      = 500;
  // Whole microseconds times clock MHz, so no time needs rounding
  localparam int unsigned MON4_MIN_CYC     = T_MON4_MIN_US * CLK_MHZ;
  localparam int unsigned MON4_MAX_CYC     = T_MON4_MAX_US * CLK_MHZ;
  localparam int unsigned MON5_MAX_CYC     = T_MON5_MAX_US * CLK_MHZ;
  localparam int unsigned PARK_MAX_CYC     = T_PARK_MAX_US * CLK_MHZ;
  localparam int unsigned W2_MAX_CYC       = T_W2_MAX_US * CLK_MHZ;
  // Wait before parking: least time plus small margin for the synchroniser
  localparam int unsigned PARK_DLY_CYC     = MON4_MIN_CYC + 8;
  // Hold stages at half of their longest time
  localparam int unsigned PARK_HOLD_CYC    = PARK_MAX_CYC / 2;
  localparam int unsigned DISCH_HOLD_CYC   = W2_MAX_CYC / 2;
  localparam int unsigned CNT_W            = 16;

  // ************************************************************
  // Clock monitor: block clock cycles over 16 oscillator periods
  // ************************************************************
  localparam int unsigned OSC_KHZ          = 2000;
  localparam int unsigned MON_PERIODS      = 16;
  localparam int unsigned MON_NOM_CYC      = MON_PERIODS * CLK_MHZ * 1000 / OSC_KHZ;
  localparam logic [9:0]  MON_MIN_CYC      = 10'h118;
  localparam logic [9:0]  MON_MAX_CYC      = 10'h172;

  // ************************************************************
  // Sequencer states and output carrier
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ARMED = 3'b001,
    ST_PARK  = 3'b010,
    ST_DISCH = 3'b011,
    ST_DONE  = 3'b100
  } pds_state_type;

  typedef struct packed {
    logic mirror_park_n;
    logic offset_discharge;
    logic system_reset_n;
  } pds_ctl_type;

  localparam pds_ctl_type CTL_RESET = '{mirror_park_n: 1'b1, offset_discharge: 1'b0,
                                        system_reset_n: 1'b1};

endpackage

//--- pds_sequencer.sv
/*
  Power-down sequencer with clock monitor, all logic in one module.
  Assumes supply trip, system-on request and oscillator arrive as
  asynchronous pins; the block clock is the monitored sequencer clock.
*/
`timescale 1ns/1ps

// Behaviour
// - Start power-down on supply trip or request drop
// - Supply trip parks mirrors after 52 to 120 us
// - Request fall parks mirrors within 1 ms
// - Offset rail discharge within 280 us of parking
// - System reset low within 500 us of discharge
// - Monitor sequencer clock against internal oscillator
module pds_sequencer
  import pds_pkg::*;
#(
  parameter int unsigned PARK_HOLD  = PARK_HOLD_CYC,
  parameter int unsigned DISCH_HOLD = DISCH_HOLD_CYC
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // Asynchronous sense pins
  input  wire logic main_supply_low_in,
  input  wire logic system_on_request_in,
  input  wire logic osc_clock_in,
  // Sequencer outputs
  output logic      mirror_park_n_out,
  output logic      mirror_offset_discharge_out,
  output logic      system_reset_n_out,
  output logic      sequence_active_out,
  output logic      clock_fault_out
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [1:0]    trip_sync;
  logic [2:0]    req_sync;
  logic [2:0]    osc_sync;
  logic          req_fall;
  logic          osc_rise;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trip_sync <= 2'h0;
      req_sync  <= 3'h0;
      osc_sync  <= 3'h0;
    end else begin
      trip_sync <= {trip_sync[0], main_supply_low_in};
      req_sync  <= {req_sync[1:0], system_on_request_in};
      osc_sync  <= {osc_sync[1:0], osc_clock_in};
    end
  end

  // Only the second and third stages are looked at
  assign req_fall = req_sync[2] & ~req_sync[1];
  assign osc_rise = ~osc_sync[2] & osc_sync[1];

  // ************************************************************
  // Power-down state machine
  // ************************************************************
  pds_state_type state;
  pds_state_type next_state;
  logic [CNT_W-1:0] cnt;
  logic          trigger;
  logic          done_wait;
  logic [CNT_W-1:0] wait_len;
  pds_ctl_type   ctl;

  assign trigger = trip_sync[1] | req_fall;

  always_comb begin
    case (state)
      ST_ARMED: wait_len = CNT_W'(PARK_DLY_CYC);
      ST_PARK:  wait_len = CNT_W'(PARK_HOLD);
      ST_DISCH: wait_len = CNT_W'(DISCH_HOLD);
      default:  wait_len = CNT_W'(1);
    endcase
  end

  assign done_wait = (cnt == wait_len - CNT_W'(1));

  // Later triggers are ignored once running, so the order cannot break
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (trigger) next_state = ST_ARMED;
      ST_ARMED: if (done_wait) next_state = ST_PARK;
      ST_PARK:  if (done_wait) next_state = ST_DISCH;
      ST_DISCH: if (done_wait) next_state = ST_DONE;
      ST_DONE:  next_state = ST_DONE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= (next_state != state) ? '0 : cnt + CNT_W'(1);
    end
  end

  // Outputs are registered from the next state so they change with it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl <= CTL_RESET;
    end else begin
      ctl.mirror_park_n    <= !(next_state inside {ST_PARK, ST_DISCH, ST_DONE});
      ctl.offset_discharge <= (next_state inside {ST_DISCH, ST_DONE});
      ctl.system_reset_n   <= (next_state != ST_DONE);
    end
  end

  logic active;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      active <= 1'b0;
    end else begin
      active <= (next_state != ST_IDLE);
    end
  end

  assign mirror_park_n_out           = ctl.mirror_park_n;
  assign mirror_offset_discharge_out = ctl.offset_discharge;
  assign system_reset_n_out          = ctl.system_reset_n;
  assign sequence_active_out         = active;

  // ************************************************************
  // Clock monitor
  // ************************************************************
  // Ratio window tolerates oscillator spread and clock spread spectrum
  logic [3:0]    per_cnt;
  logic [9:0]    clk_cnt;
  logic          mon_run;
  logic          fault;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      per_cnt <= 4'h0;
      clk_cnt <= 10'h000;
      mon_run <= 1'b0;
      fault   <= 1'b0;
    end else begin
      if (osc_rise && per_cnt == 4'hf) begin
        // First window starts at reset release, not on an edge, so it is not judged
        clk_cnt <= 10'h001;
        mon_run <= 1'b1;
        if (mon_run && (clk_cnt < MON_MIN_CYC || clk_cnt > MON_MAX_CYC)) begin
          fault <= 1'b1;
        end
      end else if (clk_cnt != 10'h3ff) begin
        clk_cnt <= clk_cnt + 10'h001;
      end
      if (osc_rise) begin
        per_cnt <= per_cnt + 4'h1;
      end
      // A stopped oscillator also counts as a fault, whatever edge arrives
      if (clk_cnt == 10'h3ff) begin
        fault <= 1'b1;
      end
    end
  end

  assign clock_fault_out = fault;

  // ************************************************************
  // Checks
  // ************************************************************
  int unsigned since_trip;
  int unsigned since_stage;
  logic        by_trip;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      since_trip  <= 0;
      since_stage <= 0;
      by_trip     <= 1'b0;
    end else begin
      since_trip  <= (state == ST_IDLE) ? 0 : since_trip + 1;
      since_stage <= (next_state != state) ? 0 : since_stage + 1;
      if (state == ST_IDLE) begin
        by_trip <= trip_sync[1];
      end
    end
  end

  sequence s_park_fall;
    $fell(mirror_park_n_out);
  endsequence

  sequence s_disch_rise;
    $rose(mirror_offset_discharge_out);
  endsequence

  a_trigger_starts: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (state == ST_IDLE && trigger) |=> state == ST_ARMED)
    else $error("trigger did not start power-down");

  a_trip_park_window: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (s_park_fall ##0 by_trip) |->
      (since_trip + 4 >= MON4_MIN_CYC && since_trip + 4 <= MON4_MAX_CYC))
    else $error("park after supply trip outside 52 to 120 us");

  a_req_park_bound: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_park_fall |-> since_trip + 4 <= MON5_MAX_CYC)
    else $error("park after request fall later than 1 ms");

  a_park_to_disch: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !mirror_park_n_out && !mirror_offset_discharge_out |-> since_stage < PARK_MAX_CYC)
    else $error("discharge not started within 280 us of park");

  a_disch_to_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mirror_offset_discharge_out && system_reset_n_out |-> since_stage < W2_MAX_CYC)
    else $error("reset not asserted within 500 us of discharge");

  a_seq_order: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_disch_rise |-> !mirror_park_n_out && system_reset_n_out)
    else $error("discharge began out of order");

  a_reset_order: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(system_reset_n_out) |-> mirror_offset_discharge_out && !mirror_park_n_out)
    else $error("reset asserted out of order");

  a_mon_stall: assert property (@(posedge clk_in) disable iff (!nrst_in)
    clk_cnt == 10'h3ff |=> clock_fault_out)
    else $error("stopped oscillator not flagged");

endmodule // pds_sequencer

//--- tb.sv
/*
  Testbench of the power-down sequencer: triggers, step timing, clock monitor.
  Assumes small hold parameters and the host model on the far side.
*/
`timescale 1ns/1ps
module tb;
  import pds_pkg::*;
  localparam int unsigned HOLD = 20;
  localparam int          TMO  = 60000;
  logic        clk_in;
  logic        nrst_in;
  logic        trip;
  logic        off;
  logic [9:0]  osc_half;
  logic        supply_low;
  logic        request;
  logic        osc;
  wire         park_n;
  wire         disch;
  wire         rst_n;
  wire pds_ctl_type ctl;
  logic        active;
  logic        fault;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          cyc         = 0;

  pds_sequencer #(.PARK_HOLD(HOLD), .DISCH_HOLD(HOLD)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .main_supply_low_in(supply_low),
    .system_on_request_in(request), .osc_clock_in(osc),
    .mirror_park_n_out(park_n),
    .mirror_offset_discharge_out(disch),
    .system_reset_n_out(rst_n), .sequence_active_out(active),
    .clock_fault_out(fault));
  assign ctl = {park_n, disch, rst_n};
  pds_host_model host (.trip_in(trip), .off_in(off), .osc_half_in(osc_half),
    .supply_low_out(supply_low), .request_out(request), .osc_out(osc));

  // ************************************************************
  // Clock, timeout and shared tasks
  // ************************************************************
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      error_cnt++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk_in);
    #2;
  endtask
  task automatic do_reset;
    nrst_in = 1'b0;
    trip    = 1'b0;
    off     = 1'b1;
    repeat (12) tick();
    nrst_in = 1'b1;
    repeat (4) tick();
    // Request rises after release so that a later drop is a real fall
    off = 1'b0;
    repeat (8) tick();
    check(32'(ctl), 32'(CTL_RESET));
    check(32'(active), 32'h0);
    check(32'(fault), 32'h0);
  endtask
  task automatic wait_for(input logic [2:0] want, input int lim, output int n);
    n = 0;
    while (ctl !== want && n < lim) begin
      tick();
      n++;
    end
  endtask
  // Park count comes back to the caller, whose limits depend on the trigger
  task automatic walk(output int np);
    int n;
    wait_for(3'h1, 45000, np);
    check(32'(active), 32'h1);
    wait_for(3'h3, 11300, n);
    check(32'(n <= PARK_MAX_CYC), 32'h1);
    wait_for(3'h2, 20100, n);
    check(32'(n <= W2_MAX_CYC), 32'h1);
    repeat (200) tick();
    check(32'(ctl), 32'h2);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic supply_trip;
    int np;
    do_reset();
    trip = 1'b1;
    walk(np);
    check(32'(np >= MON4_MIN_CYC && np <= MON4_MAX_CYC), 32'h1);
  endtask
  task automatic request_drop;
    int np;
    do_reset();
    off = 1'b1;
    walk(np);
    check(32'(np <= MON5_MAX_CYC), 32'h1);
  endtask
  // Supply recovers and the request drops while the trip sequence runs
  task automatic both_triggers;
    int np;
    do_reset();
    trip = 1'b1;
    repeat (500) tick();
    trip = 1'b0;
    repeat (500) tick();
    off = 1'b1;
    walk(np);
    check(32'(np + 1000 >= MON4_MIN_CYC && np + 1000 <= MON4_MAX_CYC), 32'h1);
  endtask
  task automatic clock_monitor;
    // Nominal, too fast, too slow, stopped
    logic [9:0] half [4] = '{10'h0fa, 10'h0be, 10'h12c, 10'h000};
    logic       bad  [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      osc_half = 10'h0fa;
      do_reset();
      repeat (1500) tick();
      osc_half = half[i];
      repeat (3000) tick();
      check(32'(fault), 32'(bad[i]));
      check(32'(ctl), 32'(CTL_RESET));
    end
    osc_half = 10'h0fa;
  endtask
  task automatic results;
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    osc_half = 10'h0fa;
    supply_trip();
    request_drop();
    both_triggers();
    clock_monitor();
    results();
  end
endmodule // tb
